// File: verilog/led_dim_defines.svh
// Register offsets, reset values and timing counts for the LED dimming block
`ifndef LED_DIM_DEFINES_SVH
`define LED_DIM_DEFINES_SVH

`define OFS_PWM_BRIGHTNESS_LEVEL 8'h00
`define OFS_DIMMING_SOURCE_SELECT 8'h01
`define OFS_DC_CURRENT_LEVEL 8'h07
`define RST_PWM_BRIGHTNESS_LEVEL 8'hFF
`define RST_DC_CURRENT_LEVEL 8'hFF
`define RST_DIMMING_SOURCE_SELECT 8'h01
`define MODE_INTERNAL 8'h05
`define MODE_EXTERNAL 8'h03
`define MODE_RATIO 8'h01
`define FULL_SCALE 8'hFF
`define CLK_FREQ_HZ 50000000
`define ENABLE_PULSE_NS 40000
`define SHUTDOWN_IDLE_US 28000
`define ENABLE_PULSE_CYC ((`ENABLE_PULSE_NS * 50 + 999) / 1000)
`define SHUTDOWN_IDLE_CYC (`SHUTDOWN_IDLE_US * 50)
`define DIM_PERIOD_CYC 250000

`endif

// File: verilog/led_dim_pkg.sv
// Types shared by the LED dimming block
package led_dim_pkg;
  typedef enum logic [1:0] {
    DIM_INTERNAL = 2'b00,
    DIM_EXTERNAL = 2'b01,
    DIM_RATIO = 2'b10,
    DIM_DC_TO_PWM = 2'b11
  } dim_source_t;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_ARMING = 2'b01,
    PWR_ON = 2'b10
  } power_state_t;
endpackage

// File: verilog/led_dimming_pwm_control.sv
// Dimming control: register port, enable detection, PWM generation
`timescale 1ns/10ps
`include "led_dim_defines.svh"

module led_dimming_pwm_control
  import led_dim_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int DIM_PERIOD_CYC = `DIM_PERIOD_CYC,
  parameter int ENABLE_PULSE_CYC = `ENABLE_PULSE_CYC,
  parameter int SHUTDOWN_IDLE_CYC = `SHUTDOWN_IDLE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic enable_dim_pin_in,
  input wire logic dc_to_pwm_sel_in,
  input wire logic [7:0] averaged_dim_node_in,
  output logic [7:0] reg_rdata_out,
  output logic device_enabled_out,
  output logic [7:0] channel_current_level_out,
  output logic [CHANNELS-1:0] channel_on_out
);

  localparam int PW = $clog2(DIM_PERIOD_CYC + 1);
  localparam int SW = $clog2(SHUTDOWN_IDLE_CYC + 1);

  // Register file and read data
  logic [7:0] brt_r, brt_nxt;
  logic [7:0] dcl_r, dcl_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  function automatic logic [7:0] read_mux(input logic [7:0] addr,
    input logic [7:0] b, input logic [7:0] m, input logic [7:0] d);
    case (addr)
      `OFS_PWM_BRIGHTNESS_LEVEL: read_mux = b;
      `OFS_DIMMING_SOURCE_SELECT: read_mux = m;
      `OFS_DC_CURRENT_LEVEL: read_mux = d;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    brt_nxt = brt_r;
    dcl_nxt = dcl_r;
    mode_nxt = mode_r;
    rdata_nxt = rdata_r;
    if (reg_wr_in) begin
      if (reg_addr_in == `OFS_PWM_BRIGHTNESS_LEVEL)
        brt_nxt = reg_wdata_in;
      if (reg_addr_in == `OFS_DIMMING_SOURCE_SELECT)
        mode_nxt = reg_wdata_in;
      if (reg_addr_in == `OFS_DC_CURRENT_LEVEL)
        dcl_nxt = reg_wdata_in;
    end
    if (reg_rd_in)
      rdata_nxt = read_mux(reg_addr_in, brt_r, mode_r, dcl_r);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brt_r <= `RST_PWM_BRIGHTNESS_LEVEL;
      dcl_r <= `RST_DC_CURRENT_LEVEL;
      mode_r <= `RST_DIMMING_SOURCE_SELECT;
      rdata_r <= 8'h00;
    end else begin
      brt_r <= brt_nxt;
      dcl_r <= dcl_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Mode decode; unknown codes fall back to ratio dimming
  dim_source_t src;
  always_comb begin
    case (mode_r)
      `MODE_INTERNAL: src = DIM_INTERNAL;
      `MODE_EXTERNAL: src = DIM_EXTERNAL;
      `MODE_RATIO: src = dc_to_pwm_sel_in ? DIM_DC_TO_PWM : DIM_RATIO;
      default: src = DIM_RATIO;
    endcase
  end

  // Enable detection and idle shutdown
  power_state_t pwr_r, pwr_nxt;
  logic [SW-1:0] hi_cnt_r, hi_cnt_nxt;
  logic [SW-1:0] idle_cnt_r, idle_cnt_nxt;
  logic pin_q_r, pin_q_nxt;
  logic pin_edge;
  assign pin_edge = enable_dim_pin_in ^ pin_q_r;

  always_comb begin
    pwr_nxt = pwr_r;
    hi_cnt_nxt = hi_cnt_r;
    idle_cnt_nxt = idle_cnt_r;
    pin_q_nxt = enable_dim_pin_in;
    case (pwr_r)
      PWR_OFF: begin
        hi_cnt_nxt = '0;
        idle_cnt_nxt = '0;
        if (enable_dim_pin_in)
          pwr_nxt = PWR_ARMING;
      end
      PWR_ARMING: begin
        // Short glitches drop back and wait for the next pulse
        if (!enable_dim_pin_in) begin
          pwr_nxt = PWR_OFF;
        end else if (hi_cnt_r >= SW'(ENABLE_PULSE_CYC - 2)) begin
          pwr_nxt = PWR_ON;
        end else begin
          hi_cnt_nxt = hi_cnt_r + 1'b1;
        end
      end
      PWR_ON: begin
        // A pin held high is a valid level; only a long low shuts down
        if (pin_edge || enable_dim_pin_in) begin
          idle_cnt_nxt = '0;
        end else if (idle_cnt_r >= SW'(SHUTDOWN_IDLE_CYC - 1)) begin
          pwr_nxt = PWR_OFF;
        end else begin
          idle_cnt_nxt = idle_cnt_r + 1'b1;
        end
      end
      default: pwr_nxt = PWR_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_r <= PWR_OFF;
      hi_cnt_r <= '0;
      idle_cnt_r <= '0;
      pin_q_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      pin_q_r <= pin_q_nxt;
    end
  end

  // Internal period counter and external duty measurement
  logic [PW-1:0] phase_r, phase_nxt;
  logic [PW-1:0] ext_hi_r, ext_hi_nxt;
  logic [PW-1:0] ext_duty_r, ext_duty_nxt;
  logic period_end;
  assign period_end = (phase_r == PW'(DIM_PERIOD_CYC - 1));

  always_comb begin
    phase_nxt = period_end ? '0 : phase_r + 1'b1;
    ext_hi_nxt = ext_hi_r;
    ext_duty_nxt = ext_duty_r;
    // Duty measured as high count per internal period; averaging over a
    // full internal period replaces the external RC filter
    if (period_end) begin
      ext_duty_nxt = ext_hi_r + PW'(enable_dim_pin_in);
      ext_hi_nxt = '0;
    end else if (enable_dim_pin_in) begin
      ext_hi_nxt = ext_hi_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= '0;
      ext_hi_r <= '0;
      ext_duty_r <= PW'(DIM_PERIOD_CYC);
    end else begin
      phase_r <= phase_nxt;
      ext_hi_r <= ext_hi_nxt;
      ext_duty_r <= ext_duty_nxt;
    end
  end

  // Threshold: on while phase*255*255 < brt*factor*period (ext_duty_r in place of period in ratio mode), where factor
  // is 255 - averaged_dim_node_in in DC-to-PWM mode, else 255; products are wide to avoid truncation
  localparam int TW = PW + 17;
  logic [7:0] factor;
  logic [TW-1:0] lhs, rhs;
  logic pwm_on;

  always_comb begin
    factor = `FULL_SCALE;
    lhs = TW'(phase_r) * TW'(`FULL_SCALE);
    rhs = TW'(brt_r) * TW'(DIM_PERIOD_CYC);
    pwm_on = 1'b0;
    case (src)
      DIM_INTERNAL: pwm_on = enable_dim_pin_in && (lhs < rhs);
      DIM_EXTERNAL: pwm_on = enable_dim_pin_in;
      DIM_RATIO: begin
        lhs = TW'(phase_r) * TW'(`FULL_SCALE);
        rhs = TW'(brt_r) * TW'(ext_duty_r);
        pwm_on = lhs < rhs;
      end
      DIM_DC_TO_PWM: begin
        factor = `FULL_SCALE - averaged_dim_node_in;
        lhs = TW'(phase_r) * TW'(`FULL_SCALE) * TW'(`FULL_SCALE);
        rhs = TW'(brt_r) * TW'(factor) * TW'(DIM_PERIOD_CYC);
        pwm_on = lhs < rhs;
      end
      default: pwm_on = 1'b0;
    endcase
  end

  // Output stage
  logic [CHANNELS-1:0] chan_r, chan_nxt;
  logic [7:0] lvl_r, lvl_nxt;
  logic en_r, en_nxt;

  always_comb begin
    en_nxt = (pwr_r == PWR_ON);
    lvl_nxt = dcl_r;
    chan_nxt = '0;
    if (en_nxt && pwm_on && brt_r != 8'h00 && dcl_r != 8'h00)
      chan_nxt = {CHANNELS{1'b1}};
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_r <= '0;
      lvl_r <= 8'h00;
      en_r <= 1'b0;
    end else begin
      chan_r <= chan_nxt;
      lvl_r <= lvl_nxt;
      en_r <= en_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign device_enabled_out = en_r;
  assign channel_current_level_out = lvl_r;
  assign channel_on_out = chan_r;

endmodule

// File: dv/ext_dim_src.sv
// External dimming source model on the enable/dim pin
`timescale 1ns/10ps
module ext_dim_src (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] high_in,
  output logic pin_out
);
  logic [3:0] cnt_r;
  // Period of 16 keeps every low stretch far below shutdown while high_in is nonzero
  // The bench keeps the duty inside the usable range except for one zero high_in that tests idle shutdown
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 4'h0;
      pin_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      // A high count of 16 holds the pin high for host-only dimming
      pin_out <= ({4'h0, cnt_r} < high_in);
    end
  end
endmodule

// File: dv/led_dim_props.sv
// Port assertions for the LED dimming control block
`timescale 1ns/10ps
module led_dim_props #(
  parameter int SHUTDOWN_IDLE_CYC = 64
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic enable_dim_pin_in,
  input wire logic device_enabled_out,
  input wire logic [7:0] channel_current_level_out,
  input wire logic [5:0] channel_on_out
);
  logic [7:0] brt_r, dc_r;
  int low_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brt_r <= 8'hFF;
      dc_r <= 8'hFF;
      low_r <= 0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h00) brt_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h07) dc_r <= reg_wdata_in;
      low_r <= enable_dim_pin_in ? 0 : low_r + 1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Pin high long enough while still off
  sequence arm_s;
    !device_enabled_out && enable_dim_pin_in ##1 enable_dim_pin_in [*6];
  endsequence
  a_chan_lockstep: assert property (
    channel_on_out == 6'h00 || channel_on_out == 6'h3F) else $error("lockstep");
  a_brt_zero_off: assert property (
    brt_r == 8'h00 && $past(brt_r) == 8'h00 |-> channel_on_out == 6'h00)
    else $error("brt zero");
  a_dc_level_follow: assert property (
    $past(rst_n_in) |-> channel_current_level_out == $past(dc_r))
    else $error("dc level");
  a_dc_zero_off: assert property (
    dc_r == 8'h00 && $past(dc_r) == 8'h00 |-> channel_on_out == 6'h00)
    else $error("dc zero");
  a_off_when_disabled: assert property (
    !device_enabled_out && !$past(device_enabled_out) |-> channel_on_out == 6'h00)
    else $error("disabled");
  a_enable_after_pulse: assert property (
    arm_s |=> device_enabled_out) else $error("no enable");
  a_no_early_enable: assert property (
    $rose(device_enabled_out) |-> $past(enable_dim_pin_in)
    && $past(enable_dim_pin_in, 2) && $past(enable_dim_pin_in, 3))
    else $error("early enable");
  a_idle_shutdown: assert property (
    low_r > SHUTDOWN_IDLE_CYC + 4 |-> !device_enabled_out) else $error("no off");
  a_stay_enabled: assert property (
    low_r < SHUTDOWN_IDLE_CYC - 4 && $past(device_enabled_out)
    |-> device_enabled_out) else $error("early off");
endmodule

bind led_dimming_pwm_control led_dim_props #(
  .SHUTDOWN_IDLE_CYC(SHUTDOWN_IDLE_CYC)
) props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .enable_dim_pin_in(enable_dim_pin_in),
  .device_enabled_out(device_enabled_out), .channel_on_out(channel_on_out),
  .channel_current_level_out(channel_current_level_out));

// File: dv/tb_led_dimming_pwm_control.sv
// Self-checking testbench for the LED dimming control block
`timescale 1ns/10ps
module tb_led_dimming_pwm_control;
  localparam int P = 64;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, sel = 0, win = 0, rd_d = 0;
  logic win_d = 0, pin, en;
  logic [7:0] addr = 8'h00, wdata = 8'h00, node = 8'h00, hi = 8'h10;
  logic [7:0] rdata, lvl;
  logic [5:0] on;
  logic [7:0] tv[5] = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'h33};
  int err_total = 0, checks_done = 0, cnt = 0;
  logic [7:0] rq[$];
  int dq[$];
  always #10 clk = ~clk;
  ext_dim_src src (.clk_in(clk), .rst_n_in(rst_n), .high_in(hi),
    .pin_out(pin));
  led_dimming_pwm_control #(.DIM_PERIOD_CYC(P), .ENABLE_PULSE_CYC(4),
    .SHUTDOWN_IDLE_CYC(64)) uut (.core_clk_in(clk), .rst_n_in(rst_n),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .enable_dim_pin_in(pin), .dc_to_pwm_sel_in(sel),
    .averaged_dim_node_in(node), .reg_rdata_out(rdata),
    .device_enabled_out(en), .channel_current_level_out(lvl),
    .channel_on_out(on));
  task automatic cmp(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %0d got %0d", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, e);
    rq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Counts chopped cycles over one window; settles two periods first
  task automatic duty(input int e);
    repeat (2 * P) @(posedge clk);
    dq.push_back(e);
    win <= 1'b1;
    repeat (P) @(posedge clk);
    win <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    win_d <= win;
    if (rd_d) cmp("reg_rdata_out", {24'h0, rq.pop_front()}, {24'h0, rdata});
    if (win) cnt <= cnt + int'(on === 6'h3F);
    if (win_d && !win) begin
      cmp("channel_on_out", dq.pop_front(), cnt);
      cnt <= 0;
    end
  end
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(49));
    tv[4] = 8'($urandom_range(254, 2));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(8'h00, 8'hFF);
    rd_reg(8'h01, 8'h01);
    rd_reg(8'h07, 8'hFF);
    wr_reg(8'h05, tv[4]);
    rd_reg(8'h05, 8'h00);
    wr_reg(8'h07, tv[4]);
    rd_reg(8'h07, tv[4]);
    cmp("channel_current_level_out", {24'h0, tv[4]}, {24'h0, lvl});
    wr_reg(8'h01, 8'h05);
    foreach (tv[i]) begin
      wr_reg(8'h00, tv[i]);
      duty((tv[i] * P + 254) / 255);
    end
    wr_reg(8'h07, 8'h00);
    duty(0);
    wr_reg(8'h07, 8'hFF);
    hi <= 8'h06;
    wr_reg(8'h01, 8'h01);
    foreach (tv[i]) begin
      wr_reg(8'h00, tv[i]);
      duty((tv[i] * 24 + 254) / 255);
    end
    wr_reg(8'h01, 8'h03);
    duty(24);
    hi <= 8'h10;
    sel <= 1'b1;
    wr_reg(8'h00, 8'hFF);
    wr_reg(8'h01, 8'h01);
    foreach (tv[i]) begin
      node <= tv[i];
      duty((255 * (255 - tv[i]) * P + 65024) / 65025);
    end
    hi <= 8'h00;
    duty(0);
    cmp("device_enabled_out", 32'h0, {31'h0, en});
    hi <= 8'h10;
    node <= 8'h00;
    duty(P);
    cmp("device_enabled_out", 32'h1, {31'h0, en});
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(8'h00, 8'hFF);
    end_of_test();
  end
endmodule
